// ==== umh_regs.vh ====
// Register offsets, field positions and reset values for the modem block
// Assumes a byte-addressed plain register port, 8-bit data, 4 channels
`ifndef UMH_REGS_VH
`define UMH_REGS_VH
`define UMH_ADDR_W 5
`define UMH_DATA_W 8
`define UMH_NCH 4
// Per channel: base = channel * stride
`define UMH_CH_STRIDE 5'h08
`define UMH_OFF_MCR 3'h4
`define UMH_OFF_MSR 3'h6
`define UMH_OFF_EFR 3'h2
`define UMH_OFF_TXST 3'h5
`define UMH_OFF_ISTAT 5'h1C
`define UMH_OFF_IMASK 5'h1D
`define UMH_OFF_TXSUM 5'h1E
// Modem control fields
`define UMH_MCR_DTR 0
`define UMH_MCR_RTS 1
// Modem status fields
`define UMH_MSR_DCTS 0
`define UMH_MSR_DDSR 1
`define UMH_MSR_TERI 2
`define UMH_MSR_DDCD 3
`define UMH_MSR_CTS 4
`define UMH_MSR_DSR 5
`define UMH_MSR_RI 6
`define UMH_MSR_CD 7
// Enhanced feature fields
`define UMH_EFR_ARTS 6
`define UMH_EFR_ACTS 7
// Transmit status fields
`define UMH_TXST_SPACE 0
`define UMH_TXST_GO 1
`define UMH_TXST_RTSPIN 2
// Reset values
`define UMH_MCR_RST 8'h00
`define UMH_EFR_RST 8'h00
`define UMH_IMASK_RST 8'h00
`endif

// ==== umh_sync2.v ====
// Two flip-flop synchroniser for a bundle of asynchronous pin levels
// Assumes pins settle between edges; resets to the inactive high level
module umh_sync2 #(
   parameter W = 4
) (
   input wire i_clk,
   input wire i_rst_n,
   input wire [W-1:0] i_async,
   output reg [W-1:0] o_sync
);
   reg [W-1:0] meta;

   // First stage feeds only the second stage
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         meta <= {W{1'b1}};
         o_sync <= {W{1'b1}};
      end else begin
         meta <= i_async;
         o_sync <= meta;
      end
   end
endmodule

// ==== umh_irq.v ====
// Sticky interrupt status with mask and write-one-to-clear
// Assumes one-cycle event pulses from the same clock domain
module umh_irq #(
   parameter W = 8
) (
   input wire i_clk,
   input wire i_rst_n,
   input wire [W-1:0] i_event,
   input wire [W-1:0] i_clear,
   input wire [W-1:0] i_mask_wdata,
   input wire i_mask_we,
   output reg [W-1:0] o_status,
   output reg [W-1:0] o_mask,
   output wire o_irq
);
   // Set wins over clear so no event is lost
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_status <= {W{1'b0}};
         o_mask <= {W{1'b0}};
      end else begin
         o_status <= (o_status & ~i_clear) | i_event;
         if (i_mask_we)
            o_mask <= i_mask_wdata;
      end
   end

   // Level output while any unmasked bit is pending
   assign o_irq = |(o_status & o_mask);
endmodule

// ==== umh_modem.v ====
// Modem handshake pins, transmit-ready outputs and their registers
// Assumes FIFO full flags come from the same clock; modem pins are async
// Functional notes
// - Channel tx-ready pin low while its transmit buffer has a free slot
// - Channel tx-ready pin high once its transmit buffer is full
// - Per-channel tx-ready pins plus one combined AND-ed output
// - Combined tx-ready low while any channel has space, else high
// - Per-channel transmit status readable through registers; channel 3's status offset decodes to IMASK, so only channels 0 to 2 have one
// - Low carrier-detect input means carrier present
// - Clear-to-send state reads in modem status bit 4
// - Clear-to-send gates transmit only with auto-CTS in feature bit 7
// - Low data-set-ready means modem ready; no effect on data flow
// - Modem control bit 0 set drives terminal-ready pin low
// - Bit 0 clear or reset drives terminal-ready high; no data effect
// - Ring input rising to high raises an interrupt
// - Modem control bit 1 set drives request-to-send pin low
// - Reset drives every request-to-send pin high
// - Request-to-send joins flow control only with auto-RTS bit 6
// - Clock input may be crystal or external clock; i_clk here takes an external clock only
module umh_modem (
   input wire i_clk,
   input wire i_rst_n,
   input wire [4:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [7:0] o_rdata,
   input wire [3:0] i_tx_full,
   input wire [3:0] i_rx_above_trig,
   input wire [3:0] i_cd_n,
   input wire [3:0] i_cts_n,
   input wire [3:0] i_dsr_n,
   input wire [3:0] i_ri_n,
   output reg [3:0] o_dtr_n,
   output reg [3:0] o_rts_n,
   output reg [3:0] o_tx_space_ready_n,
   output reg o_tx_space_ready_all_n,
   output wire [3:0] o_tx_go,
   output wire o_irq
);
`include "umh_regs.vh"

   // Channel decode used by both read and write paths
   function [1:0] umh_chan;
      input [4:0] a;
      begin
         umh_chan = a[4:3];
      end
   endfunction

   function umh_hit;
      input [4:0] a;
      input [2:0] off;
      begin
         umh_hit = (a[4:3] != 2'h3 || a[2] == 1'b0 || 1'b1)
            && (a[2:0] == off) && !(a >= `UMH_OFF_ISTAT);
      end
   endfunction

   reg [7:0] modem_control_register [0:3];
   reg [7:0] enhanced_feature_register [0:3];
   reg [3:0] cd_q, cts_q, dsr_q, ri_q;
   reg [7:0] next_rdata;
   reg [3:0] next_dtr_n, next_rts_n;
   reg [15:0] ev;
   reg [15:0] clr;
   reg [3:0] msr_clr;
   wire [3:0] cd_s, cts_s, dsr_s, ri_s;
   wire [15:0] ist;
   wire [15:0] imask;
   wire mask_we_lo;
   integer k;

   // Pins cross into the clock domain before anything reads them
   umh_sync2 #(.W(16)) u_sync (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_async({i_ri_n, i_dsr_n, i_cts_n, i_cd_n}),
      .o_sync({ri_s, dsr_s, cts_s, cd_s})
   );

   // Previous synchronised levels for change detection
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         cd_q <= 4'hF;
         cts_q <= 4'hF;
         dsr_q <= 4'hF;
         ri_q <= 4'hF;
      end else begin
         cd_q <= cd_s;
         cts_q <= cts_s;
         dsr_q <= dsr_s;
         ri_q <= ri_s;
      end
   end

   // Events: per channel delta CTS, DSR, CD and trailing ring edge
   always @* begin
      ev = 16'h0000;
      for (k = 0; k < 4; k = k + 1) begin
         ev[4*k+0] = cts_s[k] ^ cts_q[k];
         ev[4*k+1] = dsr_s[k] ^ dsr_q[k];
         ev[4*k+2] = ri_s[k] & ~ri_q[k];
         ev[4*k+3] = cd_s[k] ^ cd_q[k];
      end
   end

   // Reading a channel's modem status clears its deltas; ack register too
   always @* begin
      clr = 16'h0000;
      msr_clr = 4'h0;
      if (i_rd && i_addr < `UMH_OFF_ISTAT
         && i_addr[2:0] == `UMH_OFF_MSR)
         msr_clr[umh_chan(i_addr)] = 1'b1;
      for (k = 0; k < 4; k = k + 1) begin
         if (msr_clr[k])
            clr[4*k +: 4] = 4'hF;
      end
      if (i_wr && i_addr == `UMH_OFF_ISTAT)
         clr[7:0] = clr[7:0] | i_wdata;
      // High status byte sits at the top of the map, just above TXSUM
      if (i_wr && i_addr == `UMH_OFF_TXSUM + 5'h01)
         clr[15:8] = clr[15:8] | i_wdata;
   end

   // One mask byte: channels 1 to 3 share the upper nibble
   assign mask_we_lo = i_wr && i_addr == `UMH_OFF_IMASK;

   umh_irq #(.W(16)) u_irq (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_event(ev),
      .i_clear(clr),
      .i_mask_wdata({i_wdata[7:4], i_wdata[7:4], i_wdata[7:4],
         i_wdata[3:0]}),
      .i_mask_we(mask_we_lo),
      .o_status(ist),
      .o_mask(imask),
      .o_irq(o_irq)
   );

   // Control register writes per channel
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         for (k = 0; k < 4; k = k + 1) begin
            modem_control_register[k] <= `UMH_MCR_RST;
            enhanced_feature_register[k] <= `UMH_EFR_RST;
         end
      end else if (i_wr && i_addr < `UMH_OFF_ISTAT) begin
         if (i_addr[2:0] == `UMH_OFF_MCR)
            modem_control_register[umh_chan(i_addr)] <= i_wdata;
         if (i_addr[2:0] == `UMH_OFF_EFR)
            enhanced_feature_register[umh_chan(i_addr)] <= i_wdata;
      end
   end

   // Handshake pins; auto-RTS also lifts RTS when the receiver is above its trigger level
   always @* begin
      for (k = 0; k < 4; k = k + 1) begin
         next_dtr_n[k] = ~modem_control_register[k][`UMH_MCR_DTR];
         next_rts_n[k] = ~modem_control_register[k][`UMH_MCR_RTS];
         if (enhanced_feature_register[k][`UMH_EFR_ARTS] && i_rx_above_trig[k])
            next_rts_n[k] = 1'b1;
      end
   end

   // Pin outputs registered; reset leaves DTR and RTS high
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_dtr_n <= 4'hF;
         o_rts_n <= 4'hF;
         o_tx_space_ready_n <= 4'h0;
         o_tx_space_ready_all_n <= 1'b0;
      end else begin
         o_dtr_n <= next_dtr_n;
         o_rts_n <= next_rts_n;
         o_tx_space_ready_n <= i_tx_full;
         o_tx_space_ready_all_n <= &i_tx_full;
      end
   end

   // Transmit may run unless auto-CTS is on and the modem holds CTS high
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_go
         assign o_tx_go[g] = ~(enhanced_feature_register[g][`UMH_EFR_ACTS] & cts_s[g]);
      end
   endgenerate

   // Read mux; DSR feeds status only, never the data path
   always @* begin
      next_rdata = 8'h00;
      if (i_addr == `UMH_OFF_ISTAT) begin
         next_rdata = ist[7:0];
      end else if (i_addr == `UMH_OFF_IMASK) begin
         next_rdata = {imask[15:12], imask[3:0]};
      end else if (i_addr == `UMH_OFF_TXSUM) begin
         next_rdata = {3'h0, o_tx_space_ready_all_n, o_tx_space_ready_n};
      end else if (i_addr == `UMH_OFF_IMASK + 5'h02) begin
         next_rdata = ist[15:8];
      end else begin
         case (i_addr[2:0])
            `UMH_OFF_MCR: next_rdata = modem_control_register[umh_chan(i_addr)];
            `UMH_OFF_EFR: next_rdata = enhanced_feature_register[umh_chan(i_addr)];
            `UMH_OFF_MSR: begin
               next_rdata[`UMH_MSR_CTS] = ~cts_s[umh_chan(i_addr)];
               next_rdata[`UMH_MSR_DSR] = ~dsr_s[umh_chan(i_addr)];
               next_rdata[`UMH_MSR_RI] = ~ri_s[umh_chan(i_addr)];
               next_rdata[`UMH_MSR_CD] = ~cd_s[umh_chan(i_addr)];
               next_rdata[3:0] = {ist[4*umh_chan(i_addr)+3],
                  ist[4*umh_chan(i_addr)+2], ist[4*umh_chan(i_addr)+1],
                  ist[4*umh_chan(i_addr)]};
            end
            `UMH_OFF_TXST: begin
               next_rdata[`UMH_TXST_SPACE] =
                  ~i_tx_full[umh_chan(i_addr)];
               next_rdata[`UMH_TXST_GO] = o_tx_go[umh_chan(i_addr)];
               next_rdata[`UMH_TXST_RTSPIN] = o_rts_n[umh_chan(i_addr)];
            end
            default: next_rdata = 8'h00;
         endcase
      end
   end

   // Read data stands in the cycle after the strobe only
   always @(posedge i_clk) begin
      if (!i_rst_n)
         o_rdata <= 8'h00;
      else if (i_rd)
         o_rdata <= next_rdata;
      else
         o_rdata <= 8'h00;
   end
endmodule

// ==== umh_modem_props.sv ====
// Checker for the modem block: pin timing and register read port
// Assumes one clock with synchronous active-low reset; bound below
module umh_modem_props (
   input logic i_clk,
   input logic i_rst_n,
   input logic [4:0] i_addr,
   input logic [7:0] i_wdata,
   input logic i_wr,
   input logic i_rd,
   input logic [7:0] o_rdata,
   input logic [3:0] i_tx_full,
   input logic [3:0] i_cts_n,
   input logic [3:0] o_dtr_n,
   input logic [3:0] o_rts_n,
   input logic [3:0] o_tx_space_ready_n,
   input logic o_tx_space_ready_all_n,
   input logic [3:0] o_tx_go,
   input logic o_irq
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking dc @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   // Control write to channels 0 to 2; channel 3's control offset lands on ISTAT
   sequence s_ctl_wr;
      i_wr && i_addr[2:0] == 3'h4 && i_addr[4:3] != 2'h3;
   endsequence
   // Past-reset guard: outputs only follow inputs one edge after release
   chk_tx_follow: assert property ($past(i_rst_n) |->
      o_tx_space_ready_n == $past(i_tx_full)) else $error("tx ready lag");
   chk_all_and: assert property ($past(i_rst_n) |->
      o_tx_space_ready_all_n == &$past(i_tx_full)) else $error("all ready");
   chk_reset_pins: assert property (!$past(i_rst_n) |->
      o_dtr_n == 4'hF && o_rts_n == 4'hF && !o_irq)
      else $error("pins not idle after reset");
   // Pins lag the register by one edge
   chk_dtr_write: assert property (s_ctl_wr |-> ##2
      o_dtr_n[$past(i_addr[4:3], 2)] == !$past(i_wdata[0], 2))
      else $error("dtr pin does not follow write");
   chk_rts_off: assert property (s_ctl_wr ##0 !i_wdata[1] |-> ##2
      o_rts_n[$past(i_addr[4:3], 2)]) else $error("rts pin low when off");
   chk_go_gate: assert property (
      $past(i_rst_n) && $past(i_rst_n, 2) && $past(i_rst_n, 3) |->
      (~o_tx_go & ~$past(i_cts_n, 2)) == 4'h0) else $error("go gated");
   chk_sum_read: assert property (i_rd && i_addr == 5'h1E |=>
      o_rdata == {3'h0, $past(o_tx_space_ready_all_n),
      $past(o_tx_space_ready_n)}) else $error("summary read wrong");
   chk_rdata_idle: assert property ($past(i_rst_n) && !$past(i_rd) |->
      o_rdata == 8'h00) else $error("read data not idle");
   chk_hole_read: assert property (i_rd && i_addr[4:3] != 2'h3 &&
      !(i_addr[2:0] inside {3'h2, 3'h4, 3'h5, 3'h6}) |=> o_rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule
bind umh_modem umh_modem_props u_props (.i_clk(i_clk), .i_rst_n(i_rst_n),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
   .o_rdata(o_rdata), .i_tx_full(i_tx_full), .i_cts_n(i_cts_n),
   .o_dtr_n(o_dtr_n), .o_rts_n(o_rts_n), .o_tx_go(o_tx_go), .o_irq(o_irq),
   .o_tx_space_ready_n(o_tx_space_ready_n),
   .o_tx_space_ready_all_n(o_tx_space_ready_all_n));

// ==== umh_modem_peer.sv ====
// Behavioural modem: drives the four status pins of every channel
// Assumes the bench sets the wanted levels {ri, dsr, cts, cd}
module umh_modem_peer (
   input logic [15:0] i_want,
   output logic [15:0] o_pins
);
   timeunit 1ns;
   timeprecision 100ps;
   initial o_pins = 16'hFFFF;
   // Odd delay keeps pin moves off the clock grid, as a real modem would
   always @(i_want) o_pins <= #3.3 i_want;
endmodule

// ==== umh_modem_tb.sv ====
// Testbench for the modem block: pins, flow gating and interrupts
// Assumes the peer model drives the async pins; bus per plain port
module umh_modem_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, all_n, irq;
   logic [4:0] i_addr = 5'h00;
   logic [7:0] i_wdata = 8'h00, rd_v, rdata;
   logic [3:0] i_tx_full = 4'h0, i_rx_above_trig = 4'h0;
   logic [3:0] dtr_n, rts_n, txr_n, go;
   logic [15:0] want = 16'hFFFF, pins;
   int failures = 0, n_tests = 0;
   umh_modem uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
      .i_tx_full(i_tx_full), .i_rx_above_trig(i_rx_above_trig),
      .i_cd_n(pins[3:0]), .i_cts_n(pins[7:4]), .i_dsr_n(pins[11:8]),
      .i_ri_n(pins[15:12]), .o_dtr_n(dtr_n), .o_rts_n(rts_n),
      .o_tx_space_ready_n(txr_n), .o_tx_space_ready_all_n(all_n),
      .o_tx_go(go), .o_irq(irq));
   umh_modem_peer peer (.i_want(want), .o_pins(pins));
   initial forever #10 i_clk = ~i_clk;
   task automatic ck(input string nm, input logic [7:0] e, g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   // Data stand only in the cycle after the strobe
   task automatic rd(input logic [4:0] a);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 rd_v = rdata;
   endtask
   task automatic rst_seq;
      @(posedge i_clk);
      i_rst_n <= 1'b0;
      repeat (20) @(posedge i_clk);
      i_rst_n <= 1'b1;
      cyc(1);
      ck("dtr", 8'h0F, {4'h0, dtr_n});
      ck("rts", 8'h0F, {4'h0, rts_n});
      ck("irq", 8'h00, {7'h00, irq});
   endtask
   // Boundary patterns: none, one, three and all channels full
   task automatic t_tx_space_ready_n;
      logic [3:0] p [4] = '{4'h0, 4'h1, 4'hE, 4'hF};
      foreach (p[k]) begin
         @(posedge i_clk);
         i_tx_full <= p[k];
         cyc(2);
         ck("txr", {4'h0, p[k]}, {4'h0, txr_n});
         ck("all", {7'h00, &p[k]}, {7'h00, all_n});
         rd(5'h1E);
         ck("sum", {3'h0, &p[k], p[k]}, rd_v);
         rd(5'h0D);
         ck("st1", {5'h00, 2'h3, ~p[k][1]}, rd_v);
      end
   endtask
   task automatic t_mctl;
      for (int c = 0; c < 3; c++) begin
         for (int v = 3; v >= 0; v--) begin
            wr({c[1:0], 3'h4}, v[7:0]);
            cyc(2);
            ck("dtr", {7'h00, ~v[0]}, {7'h00, dtr_n[c]});
            ck("rts", {7'h00, ~v[1]}, {7'h00, rts_n[c]});
            rd({c[1:0], 3'h4});
            ck("ctl", v[7:0], rd_v);
         end
      end
   endtask
   // All four pins of channel 0 go low: carrier, clear, ready, ring
   task automatic t_stat;
      rd(5'h06);
      want = 16'hEEEE;
      cyc(5);
      rd(5'h06);
      ck("sts", 8'hFB, rd_v);
      rd(5'h06);
      ck("sts2", 8'hF0, rd_v);
      ck("go", 8'h0F, {4'h0, go});
   endtask
   // Ring pin rises while masked, then unmask, then clear
   task automatic t_irq;
      wr(5'h1D, 8'h00);
      want = 16'hFFFF;
      cyc(5);
      ck("irqm", 8'h00, {7'h00, irq});
      rd(5'h1C);
      ck("ist", 8'h0F, rd_v);
      wr(5'h1D, 8'h04);
      cyc(1);
      ck("irq1", 8'h01, {7'h00, irq});
      wr(5'h1C, 8'h04);
      cyc(1);
      ck("irqc", 8'h00, {7'h00, irq});
   endtask
   task automatic t_flow;
      wr(5'h02, 8'h80);
      cyc(3);
      ck("goh", 8'h0E, {4'h0, go});
      want = 16'hFFEF;
      cyc(4);
      ck("gol", 8'h0F, {4'h0, go});
      wr(5'h02, 8'h40);
      wr(5'h04, 8'h02);
      @(posedge i_clk);
      i_rx_above_trig <= 4'h1;
      cyc(2);
      ck("rtsf", 8'h0F, {4'h0, rts_n});
      @(posedge i_clk);
      i_rx_above_trig <= 4'h0;
      cyc(2);
      ck("rtsl", 8'h0E, {4'h0, rts_n});
   endtask
   task automatic give_verdict;
      if (failures == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      rst_seq();
      t_tx_space_ready_n();
      t_mctl();
      t_stat();
      t_irq();
      t_flow();
      wr(5'h0C, 8'h03);
      rst_seq();
      give_verdict();
   end
   // Hang guard
   initial begin
      repeat (5000) @(posedge i_clk);
      failures++;
      give_verdict();
   end
endmodule
